// *** rtl/azcfb_regs.sv ***
// autozero and current feedback register front end
`timescale 1ns/1ps
`default_nettype none
// Function
// - command bit 31 is 0 for read and 1 for write, and every returned word has bit 31 at 0.
// - bits 25:24 select the channel, 01 first load and 10 second, and only it is served.
// - writing 1 to bit 23 of the autozero word starts calibration once the channel is disabled, 0 does nothing, reset 1.
// - a 13-bit read-only offset in bits 12:0 resets to 0 and loads at calibration end.
// - a write to the feedback register is treated as a read and stores none of its data.
// - in calibration mode bits 23:8 return the 16-bit raw current.
// - with select 0 bits 23:12 return the last switching cycle current value.
// - with select 0 bits 11:0 return the last switching period in 16-clock units.
// - reading feedback clears the cycle current and the peak current.
// - all measured feedback fields read zero while the channel is not operating.
// - with select 1 bits 23:16 return the peak over the last dither cycle.
// - with dither off the peak is the highest since the last read.
// - with select 1 bits 15:8 return the minimum, set to all ones after a read.
// - with select 1 bits 7:0 count switching cycles per dither cycle, zero if idle or off.
module azcfb_regs #(
  parameter int AZ_SETTLE_CYC = azcfb_pkg::AZ_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire logic [azcfb_pkg::CMD_W-1:0] cmd_word,
  output logic resp_valid,
  output logic [azcfb_pkg::CMD_W-1:0] resp_word,
  input wire logic [azcfb_pkg::NUM_CH-1:0] chan_enabled,
  input wire logic [azcfb_pkg::NUM_CH-1:0] chan_operating,
  input wire logic [azcfb_pkg::NUM_CH-1:0] cal_mode,
  input wire logic [azcfb_pkg::NUM_CH-1:0] feedback_select,
  input wire logic [azcfb_pkg::NUM_CH-1:0] dither_en,
  input wire logic [azcfb_pkg::NUM_CH-1:0] sample_valid,
  input wire logic [azcfb_pkg::NUM_CH-1:0][azcfb_pkg::PK_W-1:0] sample_cur,
  input wire logic [azcfb_pkg::NUM_CH-1:0] cycle_done,
  input wire logic [azcfb_pkg::NUM_CH-1:0][azcfb_pkg::CYC_W-1:0] cycle_cur_in,
  input wire logic [azcfb_pkg::NUM_CH-1:0][azcfb_pkg::PER_W-1:0] cycle_period_in,
  input wire logic [azcfb_pkg::NUM_CH-1:0] dither_done,
  input wire logic [azcfb_pkg::NUM_CH-1:0][azcfb_pkg::RAW_W-1:0] raw_cal_cur,
  input wire logic [azcfb_pkg::NUM_CH-1:0][azcfb_pkg::OFFSET_W-1:0] offset_meas,
  output logic [azcfb_pkg::NUM_CH-1:0] offset_cal_busy
);
  import azcfb_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // channel code decode
  function automatic logic sel_ok(input logic [1:0] sel);
    sel_ok = (sel == CH_FIRST) || (sel == CH_SECOND);
  endfunction
  function automatic logic sel_idx(input logic [1:0] sel);
    sel_idx = (sel == CH_SECOND);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // per-channel sequencers and trackers
  azcfb_chan_if ch_if [NUM_CH] ();
  logic [NUM_CH-1:0] launch;
  logic [NUM_CH-1:0] rd_clr;
  logic [NUM_CH-1:0] pend;
  logic [OFFSET_W-1:0] off_val [NUM_CH];
  logic [CYC_W-1:0] fb_cyc [NUM_CH];
  logic [PER_W-1:0] fb_per [NUM_CH];
  logic [PK_W-1:0] fb_peak [NUM_CH];
  logic [PK_W-1:0] fb_min [NUM_CH];
  logic [PK_W-1:0] fb_cnt [NUM_CH];
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    azcfb_offset_cal #(
      .SETTLE_CYC(AZ_SETTLE_CYC)
    ) u_cal (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .launch(launch[g]),
      .chan_enabled(chan_enabled[g]),
      .offset_meas(offset_meas[g]),
      .launch_pending(pend[g]),
      .busy(offset_cal_busy[g]),
      .offset_value(off_val[g])
    );
    azcfb_fb_track u_trk (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .dither_en(dither_en[g]),
      .sample_valid(sample_valid[g]),
      .sample_cur(sample_cur[g]),
      .cycle_done(cycle_done[g]),
      .cycle_cur_in(cycle_cur_in[g]),
      .cycle_period_in(cycle_period_in[g]),
      .dither_done(dither_done[g]),
      .bus(ch_if[g])
    );
    assign ch_if[g].rd_clr = rd_clr[g];
    assign fb_cyc[g] = ch_if[g].cyc_cur;
    assign fb_per[g] = ch_if[g].period;
    assign fb_peak[g] = ch_if[g].peak;
    assign fb_min[g] = ch_if[g].minv;
    assign fb_cnt[g] = ch_if[g].sw_count;
  end
  ////////////////////////////////////////////////////////////////////////////
  // command decode
  logic cmd_rw;
  logic [3:0] cmd_addr;
  logic [1:0] cmd_sel;
  logic cmd_ch_ok;
  logic cmd_idx;
  assign cmd_rw = cmd_word[RW_BIT];
  assign cmd_addr = cmd_word[ADDR_HI:ADDR_LO];
  assign cmd_sel = cmd_word[CH_HI:CH_LO];
  assign cmd_ch_ok = sel_ok(cmd_sel);
  assign cmd_idx = sel_idx(cmd_sel);
  always_comb begin
    launch = '0;
    rd_clr = '0;
    if (cmd_valid && cmd_ch_ok) begin
      if (cmd_addr == ADDR_AUTOZERO && cmd_rw && cmd_word[LAUNCH_BIT]) begin
        launch[cmd_idx] = 1'b1;
      end
      if (cmd_addr == ADDR_FEEDBACK) begin
        rd_clr[cmd_idx] = 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // response snapshot
  logic resp_valid_r, resp_valid_nxt;
  logic [CMD_W-1:0] resp_r, resp_nxt;
  always_comb begin
    resp_valid_nxt = cmd_valid;
    resp_nxt = resp_r;
    if (cmd_valid) begin
      resp_nxt = '0;
      resp_nxt[ADDR_HI:ADDR_LO] = cmd_addr;
      resp_nxt[RW_BIT] = 1'b0;
      resp_nxt[CH_HI:CH_LO] = cmd_sel;
      if (cmd_ch_ok) begin
        if (cmd_addr == ADDR_AUTOZERO) begin
          resp_nxt[LAUNCH_BIT] = pend[cmd_idx] || launch[cmd_idx];
          resp_nxt[OFFSET_W-1:0] = off_val[cmd_idx];
        end else if (cmd_addr == ADDR_FEEDBACK && chan_operating[cmd_idx]) begin
          if (cal_mode[cmd_idx]) begin
            resp_nxt[RAW_LO +: RAW_W] = raw_cal_cur[cmd_idx];
          end else if (!feedback_select[cmd_idx]) begin
            resp_nxt[CYC_LO +: CYC_W] = fb_cyc[cmd_idx];
            resp_nxt[PER_LO +: PER_W] = fb_per[cmd_idx];
          end else begin
            resp_nxt[PEAK_LO +: PK_W] = fb_peak[cmd_idx];
            resp_nxt[MIN_LO +: PK_W] = fb_min[cmd_idx];
            if (dither_en[cmd_idx]) begin
              resp_nxt[COUNT_LO +: PK_W] = fb_cnt[cmd_idx];
            end
          end
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resp_valid_r <= 1'b0;
      resp_r <= '0;
    end else if (ce) begin
      resp_valid_r <= resp_valid_nxt;
      resp_r <= resp_nxt;
    end
  end
  assign resp_valid = resp_valid_r;
  assign resp_word = resp_r;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_resp_dir_zero;
    @(posedge clk) disable iff (!rst_n)
    resp_valid |-> (resp_word[RW_BIT] == 1'b0);
  endproperty
  a_resp_dir_zero: assert property (p_resp_dir_zero)
    else $error("returned word has direction bit set");
  property p_resp_channel;
    @(posedge clk) disable iff (!rst_n)
    (ce && cmd_valid) |=> resp_valid && (resp_word[CH_HI:CH_LO] == $past(cmd_sel));
  endproperty
  a_resp_channel: assert property (p_resp_channel)
    else $error("response missing or reports wrong channel");
  property p_bad_channel_quiet;
    @(posedge clk) disable iff (!rst_n)
    (cmd_valid && !cmd_ch_ok) |-> (launch == '0) && (rd_clr == '0);
  endproperty
  a_bad_channel_quiet: assert property (p_bad_channel_quiet)
    else $error("unselected channel acted on");
  property p_launch_sets;
    @(posedge clk) disable iff (!rst_n)
    (ce && cmd_valid && cmd_ch_ok && cmd_rw && cmd_addr == ADDR_AUTOZERO
      && cmd_word[LAUNCH_BIT]) |=> pend[$past(cmd_idx)];
  endproperty
  a_launch_sets: assert property (p_launch_sets)
    else $error("start write did not request calibration");
  property p_fb_no_write;
    @(posedge clk) disable iff (!rst_n)
    (cmd_valid && cmd_addr == ADDR_FEEDBACK) |-> (launch == '0);
  endproperty
  a_fb_no_write: assert property (p_fb_no_write)
    else $error("feedback write had an effect");
  property p_idle_reads_zero;
    @(posedge clk) disable iff (!rst_n)
    (ce && cmd_valid && cmd_ch_ok && cmd_addr == ADDR_FEEDBACK && !chan_operating[cmd_idx])
      |=> (resp_word[23:0] == 24'h000000);
  endproperty
  a_idle_reads_zero: assert property (p_idle_reads_zero)
    else $error("idle channel returned nonzero feedback");
  property p_snapshot_before_clear;
    @(posedge clk) disable iff (!rst_n)
    (ce && cmd_valid && cmd_ch_ok && cmd_addr == ADDR_FEEDBACK && chan_operating[cmd_idx]
      && !cal_mode[cmd_idx] && feedback_select[cmd_idx])
      |=> (resp_word[PEAK_LO +: PK_W] == $past(fb_peak[cmd_idx]));
  endproperty
  a_snapshot_before_clear: assert property (p_snapshot_before_clear)
    else $error("peak returned after clearing");
  property p_az_read_offset;
    @(posedge clk) disable iff (!rst_n)
    (ce && cmd_valid && cmd_ch_ok && cmd_addr == ADDR_AUTOZERO)
      |=> (resp_word[OFFSET_W-1:0] == $past(off_val[cmd_idx]));
  endproperty
  a_az_read_offset: assert property (p_az_read_offset)
    else $error("autozero read returned wrong offset");
  property p_raw_readback;
    @(posedge clk) disable iff (!rst_n)
    (ce && cmd_valid && cmd_ch_ok && cmd_addr == ADDR_FEEDBACK && chan_operating[cmd_idx]
      && cal_mode[cmd_idx])
      |=> (resp_word[RAW_LO +: RAW_W] == $past(raw_cal_cur[cmd_idx]));
  endproperty
  a_raw_readback: assert property (p_raw_readback)
    else $error("raw calibration current not returned");
  property p_cycle_snapshot;
    @(posedge clk) disable iff (!rst_n)
    (ce && cmd_valid && cmd_ch_ok && cmd_addr == ADDR_FEEDBACK && chan_operating[cmd_idx]
      && !cal_mode[cmd_idx] && !feedback_select[cmd_idx])
      |=> (resp_word[CYC_LO +: CYC_W] == $past(fb_cyc[cmd_idx]))
          && (resp_word[PER_LO +: PER_W] == $past(fb_per[cmd_idx]));
  endproperty
  a_cycle_snapshot: assert property (p_cycle_snapshot)
    else $error("cycle current or period not returned before clearing");
  property p_count_dither_off;
    @(posedge clk) disable iff (!rst_n)
    (ce && cmd_valid && cmd_ch_ok && cmd_addr == ADDR_FEEDBACK && chan_operating[cmd_idx]
      && !cal_mode[cmd_idx] && feedback_select[cmd_idx] && !dither_en[cmd_idx])
      |=> (resp_word[COUNT_LO +: PK_W] == 8'h00);
  endproperty
  a_count_dither_off: assert property (p_count_dither_off)
    else $error("switching count nonzero with dither off");
endmodule
`default_nettype wire

// *** rtl/azcfb_pkg.sv ***
// constants and types shared by the autozero and feedback register block
`default_nettype none
package azcfb_pkg;
  localparam int NUM_CH = 2;
  localparam int CMD_W = 32;
  localparam int RW_BIT = 31;
  localparam int ADDR_HI = 30;
  localparam int ADDR_LO = 27;
  localparam int CH_HI = 25;
  localparam int CH_LO = 24;
  localparam int LAUNCH_BIT = 23;
  localparam logic [3:0] ADDR_AUTOZERO = 4'h7;
  localparam logic [3:0] ADDR_FEEDBACK = 4'h8;
  localparam logic [1:0] CH_FIRST = 2'b01;
  localparam logic [1:0] CH_SECOND = 2'b10;
  localparam int OFFSET_W = 13;
  localparam int RAW_W = 16;
  localparam int RAW_LO = 8;
  localparam int CYC_W = 12;
  localparam int CYC_LO = 12;
  localparam int PER_W = 12;
  localparam int PER_LO = 0;
  localparam int PK_W = 8;
  localparam int PEAK_LO = 16;
  localparam int MIN_LO = 8;
  localparam int COUNT_LO = 0;
  localparam logic LAUNCH_RST = 1'b1;
  localparam logic [OFFSET_W-1:0] OFFSET_RST = 13'h0000;
  localparam logic [PK_W-1:0] PEAK_RST = 8'h00;
  localparam logic [PK_W-1:0] MIN_RST = 8'hff;
  localparam logic [PK_W-1:0] COUNT_RST = 8'h00;
  localparam int CLK_PERIOD_NS = 100;
  localparam int AZ_SETTLE_NS = 50000;
  localparam int AZ_SETTLE_CYC = (AZ_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AZ_CNT_W = 16;
  typedef enum logic [0:0] {
    AZ_IDLE = 1'b0,
    AZ_RUN = 1'b1
  } azcfb_az_state_t;
endpackage
`default_nettype wire

// *** rtl/azcfb_chan_if.sv ***
// per-channel link between register front end and feedback tracker
`timescale 1ns/1ps
`default_nettype none
interface azcfb_chan_if;
  logic rd_clr;
  logic [11:0] cyc_cur;
  logic [11:0] period;
  logic [7:0] peak;
  logic [7:0] minv;
  logic [7:0] sw_count;
  modport trk (
    input rd_clr,
    output cyc_cur,
    output period,
    output peak,
    output minv,
    output sw_count
  );
  modport regs (
    output rd_clr,
    input cyc_cur,
    input period,
    input peak,
    input minv,
    input sw_count
  );
endinterface
`default_nettype wire

// *** rtl/azcfb_offset_cal.sv ***
// per-channel offset calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module azcfb_offset_cal #(
  parameter int SETTLE_CYC = azcfb_pkg::AZ_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic launch,
  input wire logic chan_enabled,
  input wire logic [azcfb_pkg::OFFSET_W-1:0] offset_meas,
  output logic launch_pending,
  output logic busy,
  output logic [azcfb_pkg::OFFSET_W-1:0] offset_value
);
  import azcfb_pkg::*;
  localparam logic [AZ_CNT_W-1:0] LAST = AZ_CNT_W'(SETTLE_CYC - 1);
  azcfb_az_state_t state_r, state_nxt;
  logic pend_r, pend_nxt;
  logic [AZ_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [OFFSET_W-1:0] off_r, off_nxt;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    pend_nxt = pend_r;
    cnt_nxt = cnt_r;
    off_nxt = off_r;
    case (state_r)
      AZ_IDLE: begin
        if (pend_r && !chan_enabled) begin
          state_nxt = AZ_RUN;
          cnt_nxt = '0;
        end
      end
      AZ_RUN: begin
        if (chan_enabled) begin
          state_nxt = AZ_IDLE;
        end else if (cnt_r == LAST) begin
          state_nxt = AZ_IDLE;
          off_nxt = offset_meas;
          pend_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = AZ_IDLE;
      end
    endcase
    if (launch) begin
      pend_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= AZ_IDLE;
      pend_r <= LAUNCH_RST;
      cnt_r <= '0;
      off_r <= OFFSET_RST;
    end else if (ce) begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      cnt_r <= cnt_nxt;
      off_r <= off_nxt;
    end
  end
  assign launch_pending = pend_r;
  assign busy = (state_r == AZ_RUN);
  assign offset_value = off_r;
  ////////////////////////////////////////////////////////////////////////////
  property p_offset_capture;
    @(posedge clk) disable iff (!rst_n)
    (ce && state_r == AZ_RUN && !chan_enabled && cnt_r == LAST)
      |=> (offset_value == $past(offset_meas)) && (launch_pending == $past(launch));
  endproperty
  a_offset_capture: assert property (p_offset_capture)
    else $error("offset not captured at end of calibration");
  property p_abort_enabled;
    @(posedge clk) disable iff (!rst_n)
    (ce && busy && chan_enabled) |=> !busy && $stable(offset_value);
  endproperty
  a_abort_enabled: assert property (p_abort_enabled)
    else $error("calibration kept running on enabled channel");
endmodule
`default_nettype wire

// *** rtl/azcfb_fb_track.sv ***
// per-channel feedback tracker with clear-on-read
`timescale 1ns/1ps
`default_nettype none
module azcfb_fb_track (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic dither_en,
  input wire logic sample_valid,
  input wire logic [azcfb_pkg::PK_W-1:0] sample_cur,
  input wire logic cycle_done,
  input wire logic [azcfb_pkg::CYC_W-1:0] cycle_cur_in,
  input wire logic [azcfb_pkg::PER_W-1:0] cycle_period_in,
  input wire logic dither_done,
  azcfb_chan_if.trk bus
);
  import azcfb_pkg::*;
  function automatic logic [PK_W-1:0] max8(input logic [PK_W-1:0] a, input logic [PK_W-1:0] b);
    max8 = (a > b) ? a : b;
  endfunction
  function automatic logic [PK_W-1:0] min8(input logic [PK_W-1:0] a, input logic [PK_W-1:0] b);
    min8 = (a < b) ? a : b;
  endfunction
  logic [CYC_W-1:0] cyc_r, cyc_nxt;
  logic [PER_W-1:0] per_r, per_nxt;
  logic [PK_W-1:0] peak_r, peak_nxt, min_r, min_nxt, cnt_r, cnt_nxt;
  logic [PK_W-1:0] rmax_r, rmax_nxt, rmin_r, rmin_nxt, rcnt_r, rcnt_nxt;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cyc_nxt = cyc_r;
    per_nxt = per_r;
    peak_nxt = peak_r;
    min_nxt = min_r;
    cnt_nxt = cnt_r;
    rmax_nxt = rmax_r;
    rmin_nxt = rmin_r;
    rcnt_nxt = rcnt_r;
    if (bus.rd_clr) begin
      cyc_nxt = '0;
      peak_nxt = PEAK_RST;
      min_nxt = MIN_RST;
      cnt_nxt = COUNT_RST;
    end
    if (cycle_done) begin
      cyc_nxt = cycle_cur_in;
      per_nxt = cycle_period_in;
      if (rcnt_r != 8'hff) begin
        rcnt_nxt = rcnt_r + 1'b1;
      end
    end
    if (dither_en) begin
      if (sample_valid) begin
        rmax_nxt = max8(rmax_r, sample_cur);
        rmin_nxt = min8(rmin_r, sample_cur);
      end
      if (dither_done) begin
        peak_nxt = rmax_nxt;
        min_nxt = rmin_nxt;
        cnt_nxt = rcnt_nxt;
        rmax_nxt = PEAK_RST;
        rmin_nxt = MIN_RST;
        rcnt_nxt = COUNT_RST;
      end
    end else begin
      if (sample_valid) begin
        peak_nxt = max8(peak_nxt, sample_cur);
        min_nxt = min8(min_nxt, sample_cur);
      end
      rmax_nxt = PEAK_RST;
      rmin_nxt = MIN_RST;
      rcnt_nxt = COUNT_RST;
      cnt_nxt = COUNT_RST;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cyc_r <= '0;
      per_r <= '0;
      peak_r <= PEAK_RST;
      min_r <= MIN_RST;
      cnt_r <= COUNT_RST;
      rmax_r <= PEAK_RST;
      rmin_r <= MIN_RST;
      rcnt_r <= COUNT_RST;
    end else if (ce) begin
      cyc_r <= cyc_nxt;
      per_r <= per_nxt;
      peak_r <= peak_nxt;
      min_r <= min_nxt;
      cnt_r <= cnt_nxt;
      rmax_r <= rmax_nxt;
      rmin_r <= rmin_nxt;
      rcnt_r <= rcnt_nxt;
    end
  end
  assign bus.cyc_cur = cyc_r;
  assign bus.period = per_r;
  assign bus.peak = peak_r;
  assign bus.minv = min_r;
  assign bus.sw_count = cnt_r;
  ////////////////////////////////////////////////////////////////////////////
  property p_read_clears;
    @(posedge clk) disable iff (!rst_n)
    (ce && bus.rd_clr && !sample_valid && !cycle_done && !dither_done)
      |=> (bus.peak == 8'h00) && (bus.minv == 8'hff) && (bus.cyc_cur == 12'h000)
          && (bus.sw_count == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("feedback fields not reset after read");
  property p_peak_tracks;
    @(posedge clk) disable iff (!rst_n)
    (ce && !dither_en && sample_valid) |=> (bus.peak >= $past(sample_cur))
      && (bus.minv <= $past(sample_cur));
  endproperty
  a_peak_tracks: assert property (p_peak_tracks)
    else $error("peak or minimum missed a sample");
endmodule
`default_nettype wire

// *** tb/azcfb_host_model.sv ***
// host model that sends command words and collects the answers
`timescale 1ns/1ps
`default_nettype none
module azcfb_host_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic [31:0] cmd_word,
  input wire logic resp_valid,
  input wire logic [31:0] resp_word
);
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 32'h0;
  end
  // one word out, one answer back; idle word line shows the inverse
  task automatic xfer(input logic [31:0] w, output logic [31:0] r, output logic v);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_word = w;
    @(negedge clk);
    r = resp_word;
    v = resp_valid;
    cmd_valid = 1'b0;
    cmd_word = ~w;
  endtask
endmodule
`default_nettype wire

// *** tb/autozero_and_current_feedback_regs_test.sv ***
// self-checking bench for the autozero and feedback register block
`timescale 1ns/1ps
`default_nettype none
module autozero_and_current_feedback_regs_test;
  import azcfb_pkg::*;
  logic clk, rst_n, ce, cmd_valid, resp_valid, v;
  logic [31:0] cmd_word, resp_word, r;
  logic [1:0] en, op, calm, sel, dith, sv, cd, dd, busy;
  logic [1:0][7:0] scur;
  logic [1:0][11:0] ccur, cper;
  logic [1:0][15:0] raw;
  logic [1:0][12:0] offm;
  logic [15:0] lf;
  logic [11:0] c1, p1;
  logic [7:0] pk, mn, cnt, s;
  int n_mismatch, tests_run, cycles;
  azcfb_regs #(.AZ_SETTLE_CYC(4)) uut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .resp_valid(resp_valid),
    .resp_word(resp_word), .chan_enabled(en), .chan_operating(op), .cal_mode(calm),
    .feedback_select(sel), .dither_en(dith), .sample_valid(sv), .sample_cur(scur),
    .cycle_done(cd), .cycle_cur_in(ccur), .cycle_period_in(cper), .dither_done(dd),
    .raw_cal_cur(raw), .offset_meas(offm), .offset_cal_busy(busy));
  azcfb_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .resp_valid(resp_valid), .resp_word(resp_word));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [1:0] cc(input int ch);
    return (ch == 0) ? CH_FIRST : CH_SECOND;
  endfunction
  function automatic logic [31:0] hdr(input logic [3:0] a, input logic [1:0] c,
                                      input logic [23:0] d);
    return {1'b0, a, 1'b0, c, d};
  endfunction
  function automatic logic [31:0] cw(input logic w, input logic [3:0] a,
                                     input logic [1:0] c, input logic go);
    return {w, a, 1'b0, c, go, 23'h0};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmd(input logic [31:0] w);
    host.xfer(w, r, v);
    check("resp_valid", {31'h0, v}, 32'h1);
  endtask
  task automatic rdchk(input logic [3:0] a, input int ch, input logic [23:0] d,
                       input string nm);
    cmd(cw(1'b0, a, cc(ch), 1'b0));
    check(nm, r, hdr(a, cc(ch), d));
  endtask
  task automatic wait_busy(input int ch, input logic lvl);
    int k;
    k = 0;
    while (busy[ch] !== lvl && k < 20) begin
      tick(1);
      k++;
    end
    check("offset_cal_busy", {31'h0, busy[ch]}, {31'h0, lvl});
  endtask
  // samples with a switching cycle each; running max, min and count
  task automatic feed(input int n);
    repeat (n) begin
      lf = nx(lf);
      s = lf[7:0];
      pk = (s > pk) ? s : pk;
      mn = (s < mn) ? s : mn;
      cnt++;
      sv[0] = 1'b1;
      scur[0] = s;
      cd[0] = 1'b1;
      tick(1);
      sv[0] = 1'b0;
      cd[0] = 1'b0;
    end
    tick(1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    {rst_n, op, calm, sel, dith, sv, cd, dd} = '0;
    ce = 1'b1;
    en = 2'b11;
    {scur, ccur, cper, raw, offm} = '0;
    {n_mismatch, tests_run, cycles} = '0;
    lf = 16'hce4d;
    tick(10);
    rst_n = 1'b1;
    for (int ch = 0; ch < 2; ch++) begin
      rdchk(ADDR_AUTOZERO, ch, 24'h800000, "az_reset");
      rdchk(ADDR_FEEDBACK, ch, 24'h0, "fb_idle");
    end
    // calibration of each channel in turn, enables dropped one by one and left low
    for (int ch = 0; ch < 2; ch++) begin
      lf = nx(lf);
      offm[ch] = lf[12:0];
      en[ch] = 1'b0;
      wait_busy(ch, 1'b1);
      check("other_busy", {31'h0, busy[1-ch]}, 32'h0);
      wait_busy(ch, 1'b0);
      rdchk(ADDR_AUTOZERO, ch, {11'h0, offm[ch]}, "az_done");
    end
    cmd(cw(1'b1, ADDR_AUTOZERO, CH_FIRST, 1'b0));
    check("az_nolaunch", r & 32'h80800000, 32'h0);
    cmd(cw(1'b1, ADDR_AUTOZERO, 2'b11, 1'b1));
    check("az_badch", r, hdr(ADDR_AUTOZERO, 2'b11, 24'h0));
    cmd(cw(1'b1, ADDR_AUTOZERO, 2'b00, 1'b1));
    check("az_nochan", r, hdr(ADDR_AUTOZERO, 2'b00, 24'h0));
    tick(2);
    check("busy_none", {30'h0, busy}, 32'h0);
    lf = nx(lf);
    offm[1] = lf[12:0];
    cmd(cw(1'b1, ADDR_AUTOZERO, CH_SECOND, 1'b1));
    check("az_launch", r & 32'h80800000, 32'h00800000);
    wait_busy(1, 1'b1);
    wait_busy(1, 1'b0);
    rdchk(ADDR_AUTOZERO, 1, {11'h0, offm[1]}, "az_rerun");
    rdchk(ADDR_AUTOZERO, 0, {11'h0, offm[0]}, "az_keep");
    // enable raised mid-run aborts, start stays pending, rerun once low again
    cmd(cw(1'b1, ADDR_AUTOZERO, CH_FIRST, 1'b1));
    wait_busy(0, 1'b1);
    en[0] = 1'b1;
    tick(1);
    check("abort_busy", {31'h0, busy[0]}, 32'h0);
    rdchk(ADDR_AUTOZERO, 0, {1'b1, 10'h0, offm[0]}, "az_abort");
    lf = nx(lf);
    offm[0] = lf[12:0];
    en[0] = 1'b0;
    wait_busy(0, 1'b1);
    wait_busy(0, 1'b0);
    rdchk(ADDR_AUTOZERO, 0, {11'h0, offm[0]}, "az_resume");
    // switching cycle current and period, write acts as a read
    op = 2'b11;
    for (int ch = 0; ch < 2; ch++) begin
      lf = nx(lf);
      c1 = lf[11:0];
      lf = nx(lf);
      p1 = lf[11:0];
      ccur[ch] = c1;
      cper[ch] = p1;
      cd[ch] = 1'b1;
      tick(1);
      cd[ch] = 1'b0;
      tick(1);
      // frozen clock enable: read not taken, nothing cleared
      ce = 1'b0;
      host.xfer(cw(1'b0, ADDR_FEEDBACK, cc(ch), 1'b0), r, v);
      check("ce_hold", {31'h0, v}, 32'h0);
      ce = 1'b1;
      cmd(cw(ch[0], ADDR_FEEDBACK, cc(ch), 1'b0));
      check("fb_sel0", r, hdr(ADDR_FEEDBACK, cc(ch), {c1, p1}));
      rdchk(ADDR_FEEDBACK, ch, {12'h0, p1}, "fb_clr");
    end
    op[0] = 1'b0;
    feed(1);
    rdchk(ADDR_FEEDBACK, 0, 24'h0, "fb_notop");
    op[0] = 1'b1;
    calm[0] = 1'b1;
    lf = nx(lf);
    raw[0] = lf;
    tick(2);
    rdchk(ADDR_FEEDBACK, 0, {lf, 8'h00}, "fb_raw");
    calm[0] = 1'b0;
    // peak, minimum and count with dither off, then on
    sel[0] = 1'b1;
    for (int d = 0; d < 2; d++) begin
      dith[0] = d[0];
      cmd(cw(1'b0, ADDR_FEEDBACK, CH_FIRST, 1'b0));
      dd[0] = 1'b1;
      tick(1);
      dd[0] = 1'b0;
      {pk, cnt} = '0;
      mn = 8'hff;
      lf = nx(lf);
      feed(3 + lf[2:0]);
      dd[0] = 1'b1;
      tick(1);
      dd[0] = 1'b0;
      tick(1);
      rdchk(ADDR_FEEDBACK, 0, {pk, mn, d[0] ? cnt : 8'h00}, "fb_sel1");
      rdchk(ADDR_FEEDBACK, 0, 24'h00ff00, "fb_sel1_clr");
    end
    test_done();
  end
endmodule
`default_nettype wire
